// ==== hw/ucd_pkg.sv ====
// Constants and types for the UART channel serial datapath
//
// Contract
// [RQ1] Bit-rate line; 16x logic unless external 1x
// [RQ2] Queued byte starts within two ticks
// [RQ3] Sixteen by eight FIFO, writes need enable
// [RQ4] Start, data LSB first, parity, stop bits
// [RQ5] Free-slot bid level is free count minus one
// [RQ6] Bid joins level, channel and type code
// [RQ7] Bid mode: not full, half, quarter, empty
// [RQ8] Eleven-bit entries, unused data bits zero
// [RQ9] Receiver idles after each stop bit
// [RQ10] 16x receiver validates levels, short stops
// [RQ11] Start valid if still low at count 7
// [RQ12] Sample mid-cell from the 16x counter
// [RQ13] Status formed, entry written in one step
// [RQ14] Break, framing, parity stored; overrun, change apart
// [RQ15] Break stored as zero, raises break change
// [RQ16] Framing error: nonzero character, low stop
// [RQ17] Far transmitter supplies 1x receive clock
// [RQ18] Idle line high, transmitter empty flag set
// [RQ19] Overrun flagged at overrunning start bit
package ucd_pkg;

  // ****************************************
  // Timing and field constants
  // ****************************************
  localparam logic [3:0] CELL_LAST = 4'hf;
  localparam logic [3:0] START_CHECK = 4'h7;
  localparam logic [2:0] DATA_MIN_LAST = 3'h4;
  localparam logic [1:0] LEN_MAX = 2'h3;
  localparam logic [7:0] DATA_ALL = 8'hff;
  // Arbitrary type code for the transmit source
  localparam logic [2:0] TX_BID_KIND = 3'h1;

  // Bid threshold modes
  localparam logic [1:0] BID_NOT_FULL = 2'h0;
  localparam logic [1:0] BID_HALF = 2'h1;
  localparam logic [1:0] BID_QUARTER = 2'h2;
  localparam logic [1:0] BID_EMPTY = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h2,
    ST_PAR = 3'h3,
    ST_STOP = 3'h4,
    ST_BRK = 3'h5
  } ucd_state_t;

  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } ucd_rx_entry_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [2:0] kind;
    logic [3:0] level;
  } ucd_bid_t;

  typedef struct packed {
    logic [1:0] len;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } ucd_frame_cfg_t;

endpackage

// ==== hw/ucd_channel.sv ====
// UART channel serial datapath: transmit FIFO, serializer, receiver and receive FIFO
`timescale 1ns/1ps
module ucd_channel import ucd_pkg::*; #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Baud ticks, one pulse per 16x or 1x clock
  input wire logic tx_tick_i,
  input wire logic rx_tick_i,
  // Configuration
  input wire ucd_frame_cfg_t frame_cfg_i,
  input wire logic tx_ext_clk_i,
  input wire logic tx_1x_i,
  input wire logic rx_ext_clk_i,
  input wire logic rx_1x_i,
  input wire logic [1:0] tx_bid_mode_i,
  input wire logic [1:0] channel_i,
  // Commands
  input wire logic tx_enable_i,
  input wire logic tx_reset_i,
  input wire logic rx_enable_i,
  input wire logic rx_reset_i,
  input wire logic overrun_clr_i,
  input wire logic brk_chg_clr_i,
  // Host data
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rx_pop_i,
  // Serial lines
  input wire logic rxd_i,
  output logic txd_o,
  // Status and data out
  output logic tx_ready_o,
  output logic tx_empty_o,
  output logic rx_valid_o,
  output ucd_rx_entry_t rx_entry_o,
  output logic overrun_o,
  output logic brk_chg_o,
  output ucd_bid_t tx_bid_o
);

  // ****************************************
  // Shared helpers
  // ****************************************
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] HALF_FREE = (AW + 1)'(DEPTH / 2);
  localparam logic [AW:0] QUARTER_FREE = (AW + 1)'((DEPTH * 3) / 4);

  logic [7:0] len_mask;
  logic [2:0] last_bit;
  logic tx_1x;
  logic rx_1x;
  assign len_mask = DATA_ALL >> (LEN_MAX - frame_cfg_i.len);
  assign last_bit = DATA_MIN_LAST + {1'b0, frame_cfg_i.len};
  // 1x logic clocking only with an external clock selected
  assign tx_1x = tx_ext_clk_i & tx_1x_i; // RQ1
  assign rx_1x = rx_ext_clk_i & rx_1x_i; // RQ1

  // ****************************************
  // Transmit FIFO
  // ****************************************
  logic [7:0] tf_mem [DEPTH];
  logic [AW-1:0] tf_wp_reg;
  logic [AW-1:0] tf_rp_reg;
  logic [AW:0] tf_count_reg;
  logic [AW:0] tf_count_next;
  logic [AW:0] tf_free_next;
  logic tf_push;
  logic tf_pop;
  ucd_state_t tx_state_reg;

  // Disabled transmitter drops writes rather than queueing them
  assign tf_push = wr_valid_i & tx_enable_i & (tf_count_reg != FULL) & ~tx_reset_i; // RQ3
  assign tf_pop = tx_tick_i & (tx_state_reg == ST_IDLE) & (tf_count_reg != '0) & ~tx_reset_i;
  assign tf_count_next = tf_count_reg + {{AW{1'b0}}, tf_push} - {{AW{1'b0}}, tf_pop};
  assign tf_free_next = FULL - tf_count_next;

  // Storage needs no reset
  always_ff @(posedge clock_i) begin
    if (tf_push) begin
      tf_mem[tf_wp_reg] <= wr_data_i; // RQ3
    end
  end

  // Pointers and fill count, read in arrival order
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tf_wp_reg <= '0;
      tf_rp_reg <= '0;
      tf_count_reg <= '0;
    end else if (tx_reset_i) begin
      tf_wp_reg <= '0;
      tf_rp_reg <= '0;
      tf_count_reg <= '0;
    end else begin
      tf_wp_reg <= tf_wp_reg + AW'(tf_push);
      tf_rp_reg <= tf_rp_reg + AW'(tf_pop); // RQ3
      tf_count_reg <= tf_count_next;
    end
  end

  // Bid and ready flags from the next fill level
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_bid_o <= '0;
      tx_ready_o <= 1'b0;
    end else begin
      unique case (tx_bid_mode_i)
        BID_NOT_FULL: tx_bid_o.valid <= tf_free_next != '0; // RQ7
        BID_HALF: tx_bid_o.valid <= tf_free_next >= HALF_FREE; // RQ7
        BID_QUARTER: tx_bid_o.valid <= tf_free_next >= QUARTER_FREE; // RQ7
        BID_EMPTY: tx_bid_o.valid <= tf_free_next == FULL; // RQ7
      endcase
      tx_bid_o.chan <= channel_i; // RQ6
      tx_bid_o.kind <= TX_BID_KIND; // RQ6
      tx_bid_o.level <= 4'(tf_free_next - 1'b1); // RQ5
      tx_ready_o <= tx_enable_i & (tf_count_next != FULL) & ~tx_reset_i;
    end
  end

  // ****************************************
  // Transmit serializer
  // ****************************************
  logic [3:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic tx_par_reg;
  logic tx_cell_end;
  assign tx_cell_end = tx_1x | (tx_cnt_reg == CELL_LAST);

  // Idle is polled on every tick, so a queued byte starts within two ticks
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_reg <= ST_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '0;
      tx_par_reg <= 1'b0;
      txd_o <= 1'b1;
    end else if (tx_reset_i) begin
      tx_state_reg <= ST_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      txd_o <= 1'b1;
    end else if (tx_tick_i) begin
      if (tx_state_reg == ST_IDLE) begin
        txd_o <= 1'b1; // RQ18
        if (tf_pop) begin
          tx_sh_reg <= tf_mem[tf_rp_reg] & len_mask;
          tx_par_reg <= ^(tf_mem[tf_rp_reg] & len_mask) ^ frame_cfg_i.par_odd;
          txd_o <= 1'b0; // RQ2
          tx_state_reg <= ST_START;
          tx_cnt_reg <= '0;
        end
      end else if (!tx_cell_end) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end else begin
        tx_cnt_reg <= '0;
        unique case (tx_state_reg)
          ST_START: begin
            // Start bit ends after one full cell
            txd_o <= tx_sh_reg[0]; // RQ4
            tx_sh_reg <= tx_sh_reg >> 1;
            tx_bit_reg <= '0;
            tx_state_reg <= ST_DATA;
          end
          ST_DATA: begin
            if (tx_bit_reg == last_bit) begin
              txd_o <= frame_cfg_i.par_en ? tx_par_reg : 1'b1; // RQ4
              tx_state_reg <= frame_cfg_i.par_en ? ST_PAR : ST_STOP;
              tx_bit_reg <= '0;
            end else begin
              txd_o <= tx_sh_reg[0]; // RQ4
              tx_sh_reg <= tx_sh_reg >> 1;
              tx_bit_reg <= tx_bit_reg + 3'h1;
            end
          end
          ST_PAR: begin
            txd_o <= 1'b1;
            tx_state_reg <= ST_STOP;
          end
          ST_STOP: begin
            if (frame_cfg_i.two_stop && tx_bit_reg == '0) begin
              tx_bit_reg <= 3'h1; // RQ4
            end else begin
              tx_state_reg <= ST_IDLE;
            end
          end
          default: tx_state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Empty flag: enabled, nothing queued, last stop bit finished
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_empty_o <= 1'b0;
    end else begin
      tx_empty_o <= tx_enable_i & ~tx_reset_i & (tf_count_reg == '0) & (tx_state_reg == ST_IDLE); // RQ18
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_prev_reg;
  ucd_state_t rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_par_reg;
  logic rx_cell_end;
  logic rx_start_ok;
  logic [7:0] rx_data;
  logic rx_brk;
  ucd_rx_entry_t hold_reg;
  logic hold_v_reg;
  logic rf_push;
  logic [AW:0] rf_count_reg;

  // Line passes two flops before any logic looks at it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd_i;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  assign rx_cell_end = rx_1x | (rx_cnt_reg == CELL_LAST);
  assign rx_start_ok = rx_tick_i & ~rx_reset_i & ~rx_s2_reg &
    (rx_1x ? (rx_state_reg == ST_IDLE) & rx_prev_reg & rx_enable_i
           : (rx_state_reg == ST_START) & (rx_cnt_reg == START_CHECK)); // RQ11
  // Data realigned for short characters, upper bits zero
  assign rx_data = rx_sh_reg >> (LEN_MAX - frame_cfg_i.len); // RQ8
  assign rx_brk = (rx_data == '0) & ~rx_s2_reg & ~(frame_cfg_i.par_en & rx_par_reg);

  // Previous line level at each tick, for edge search
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
    end else if (rx_tick_i) begin
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // Receive state machine; the 16x counter doubles as the bit clock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_reg <= ST_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_par_reg <= 1'b0;
    end else if (rx_reset_i) begin
      rx_state_reg <= ST_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
    end else if (rx_tick_i) begin
      rx_cnt_reg <= rx_cell_end ? 4'h0 : rx_cnt_reg + 4'h1; // RQ12
      unique case (rx_state_reg)
        ST_IDLE: begin
          rx_cnt_reg <= '0; // RQ11
          rx_bit_reg <= '0;
          if (rx_start_ok) begin
            rx_state_reg <= ST_DATA;
          end else if (rx_enable_i && rx_prev_reg && !rx_s2_reg && !rx_1x) begin
            rx_state_reg <= ST_START; // RQ11
          end
        end
        ST_START: begin
          // A glitch that returns high is thrown away
          if (rx_s2_reg) begin
            rx_state_reg <= ST_IDLE; // RQ10
          end else if (rx_start_ok) begin
            rx_cnt_reg <= '0; // RQ12
            rx_state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_cell_end) begin
            rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]}; // RQ12
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= frame_cfg_i.par_en ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_cell_end) begin
            rx_par_reg <= rx_s2_reg;
            rx_state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Stop sampled at mid-cell, so a 9/16 stop still passes
          if (rx_cell_end) begin
            rx_sh_reg <= '0;
            rx_bit_reg <= '0;
            rx_state_reg <= rx_brk ? ST_BRK : ST_IDLE; // RQ9 RQ10
          end
        end
        ST_BRK: begin
          // Break ends after two high samples in a row
          if (rx_cell_end) begin
            rx_bit_reg <= rx_s2_reg ? 3'h1 : 3'h0;
            if (rx_s2_reg && rx_bit_reg[0]) begin
              rx_state_reg <= ST_IDLE;
            end
          end
        end
        default: rx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // Completed character with its status, moved as one word
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hold_reg <= '0;
      hold_v_reg <= 1'b0;
    end else if (rx_reset_i) begin
      hold_v_reg <= 1'b0;
    end else if (rx_tick_i && rx_state_reg == ST_STOP && rx_cell_end) begin
      // Overwrites a stranded character when the FIFO stays full
      hold_reg.data <= rx_brk ? 8'h00 : rx_data; // RQ13 RQ15
      hold_reg.brk <= rx_brk; // RQ14
      hold_reg.frame <= ~rx_s2_reg & ~rx_brk & (rx_data != '0); // RQ16
      hold_reg.parity <= frame_cfg_i.par_en & ~rx_brk &
        (rx_par_reg != (^rx_data ^ frame_cfg_i.par_odd)); // RQ14
      hold_v_reg <= 1'b1;
    end else if (rf_push) begin
      hold_v_reg <= 1'b0;
    end
  end

  // Overrun and break change: a set wins over a clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_o <= 1'b0;
      brk_chg_o <= 1'b0;
    end else begin
      if (rx_start_ok && hold_v_reg && rf_count_reg == FULL) begin
        overrun_o <= 1'b1; // RQ19
      end else if (overrun_clr_i || rx_reset_i) begin
        overrun_o <= 1'b0;
      end
      if (rx_tick_i && rx_cell_end && !rx_reset_i &&
          ((rx_state_reg == ST_STOP && rx_brk) || (rx_state_reg == ST_BRK && rx_s2_reg && rx_bit_reg[0]))) begin
        brk_chg_o <= 1'b1; // RQ15
      end else if (brk_chg_clr_i) begin
        brk_chg_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive FIFO
  // ****************************************
  ucd_rx_entry_t rf_mem [DEPTH];
  logic [AW-1:0] rf_wp_reg;
  logic [AW-1:0] rf_rp_reg;
  logic [AW-1:0] rf_rp_next;
  logic [AW:0] rf_count_next;
  logic rf_pop;
  assign rf_push = hold_v_reg & (rf_count_reg != FULL) & ~rx_reset_i; // RQ13
  assign rf_pop = rx_pop_i & rx_valid_o & ~rx_reset_i;
  assign rf_rp_next = rf_rp_reg + AW'(rf_pop);
  assign rf_count_next = rf_count_reg + {{AW{1'b0}}, rf_push} - {{AW{1'b0}}, rf_pop};

  always_ff @(posedge clock_i) begin
    if (rf_push) begin
      rf_mem[rf_wp_reg] <= hold_reg; // RQ8
    end
  end

  // Head word registered, with bypass for a write into an empty FIFO
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rf_wp_reg <= '0;
      rf_rp_reg <= '0;
      rf_count_reg <= '0;
      rx_valid_o <= 1'b0;
      rx_entry_o <= '0;
    end else if (rx_reset_i) begin
      rf_wp_reg <= '0;
      rf_rp_reg <= '0;
      rf_count_reg <= '0;
      rx_valid_o <= 1'b0;
    end else begin
      rf_wp_reg <= rf_wp_reg + AW'(rf_push);
      rf_rp_reg <= rf_rp_next;
      rf_count_reg <= rf_count_next;
      rx_valid_o <= rf_count_next != '0;
      rx_entry_o <= (rf_push && rf_wp_reg == rf_rp_next) ? hold_reg : rf_mem[rf_rp_next];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_idle_high;
    tx_empty_o |-> txd_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while empty"); // RQ18

  property p_start_latency;
    (tx_state_reg == ST_IDLE && tf_count_reg != '0 && tx_tick_i && !tx_reset_i) |=> (tx_state_reg == ST_START && !txd_o);
  endproperty
  a_start_latency: assert property (p_start_latency) else $error("queued byte not started"); // RQ2

  // Start bit holds low for the whole 16x cell, counter climbing one per tick
  property p_start_cell;
    (tx_state_reg == ST_START && tx_tick_i && tx_cnt_reg != CELL_LAST && !tx_1x && !tx_reset_i)
      |=> (tx_state_reg == ST_START && !txd_o && tx_cnt_reg == $past(tx_cnt_reg) + 4'h1);
  endproperty
  a_start_cell: assert property (p_start_cell) else $error("start cell counter wrong"); // RQ4

  property p_refuse_write;
    (wr_valid_i && !tx_enable_i && !tf_pop && !tx_reset_i) |=> tf_count_reg == $past(tf_count_reg);
  endproperty
  a_refuse_write: assert property (p_refuse_write) else $error("write taken while disabled"); // RQ3

  property p_bid_level;
    (tx_bid_mode_i == BID_NOT_FULL && tf_count_next == '0) |=> (tx_bid_o.valid && tx_bid_o.level == 4'hf);
  endproperty
  a_bid_level: assert property (p_bid_level) else $error("empty bid level wrong"); // RQ5

  property p_bid_empty_mode;
    (tx_bid_mode_i == BID_EMPTY && tf_count_next != '0) |=> !tx_bid_o.valid;
  endproperty
  a_bid_empty_mode: assert property (p_bid_empty_mode) else $error("bid before empty"); // RQ7

  property p_start_reject;
    (rx_state_reg == ST_START && rx_tick_i && rx_s2_reg && !rx_reset_i) |=> rx_state_reg == ST_IDLE;
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("glitch accepted"); // RQ11

  property p_start_accept;
    (rx_state_reg == ST_START && rx_tick_i && !rx_s2_reg && rx_cnt_reg == START_CHECK && !rx_reset_i)
      |=> (rx_state_reg == ST_DATA && rx_cnt_reg == '0);
  endproperty
  a_start_accept: assert property (p_start_accept) else $error("valid start lost"); // RQ11

  // Checked at the load, so a later host clear of the change flag cannot trip it
  property p_break_zero;
    (rx_tick_i && rx_state_reg == ST_STOP && rx_cell_end && rx_brk && !rx_reset_i)
      |=> (hold_v_reg && hold_reg.brk && hold_reg.data == '0 && !hold_reg.frame && brk_chg_o);
  endproperty
  a_break_zero: assert property (p_break_zero) else $error("break entry not zero"); // RQ15

  property p_overrun;
    (rx_start_ok && hold_v_reg && rf_count_reg == FULL) |=> overrun_o;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RQ19

  c_tx_start: cover property (tx_state_reg == ST_IDLE ##1 tx_state_reg == ST_START);
  c_rx_break: cover property (rx_state_reg == ST_BRK ##[1:400] rx_state_reg == ST_IDLE);
  c_overrun: cover property ($rose(overrun_o));
  c_frame: cover property (rf_push && hold_reg.frame);

endmodule

// ==== sim/ucd_far_uart.sv ====
// Remote UART model facing the serial lines of the channel
`timescale 1ns/1ps
module ucd_far_uart import ucd_pkg::*; (
  // Clock and shared 16x tick
  input wire logic clock_i,
  input wire logic tick_i,
  // Serial lines and framing
  input wire logic txd_i,
  input wire ucd_frame_cfg_t cfg_i,
  output logic rxd_o
);
  logic [7:0] got_q[$];

  // Marking level while no frame is sent
  initial rxd_o = 1'b1;

  // ****************************************
  // Tick timing
  // ****************************************
  // Waits n ticks, then steps just past the edge
  task automatic wt(input int n);
    repeat (n) begin
      @(posedge clock_i);
      while (tick_i !== 1'b1) @(posedge clock_i);
    end
    #1;
  endtask

  // One frame LSB first; parity may be spoiled, stop may be low
  task automatic send(input logic [7:0] d, input logic par_bad, input logic stop_low);
    logic p;
    p = ^(d & ~(8'hff << (int'(cfg_i.len) + 5))) ^ cfg_i.par_odd ^ par_bad;
    rxd_o = 1'b0;
    wt(16);
    for (int i = 0; i <= int'(cfg_i.len) + 4; i++) begin
      rxd_o = d[i];
      wt(16);
    end
    if (cfg_i.par_en) begin
      rxd_o = p;
      wt(16);
    end
    rxd_o = ~stop_low;
    wt(16);
    rxd_o = 1'b1;
    // Break ends only after high cells, so leave room
    if (stop_low) wt(48);
  endtask

  // Short low pulse that must not count as a start
  task automatic glitch(input int n);
    rxd_o = 1'b0;
    wt(n);
    rxd_o = 1'b1;
    wt(32);
  endtask

  // Sampler of the channel output, mid-cell, 8 bits and stop
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd_i);
      wt(8);
      for (int i = 0; i < 8; i++) begin
        wt(16);
        b[i] = txd_i;
      end
      wt(16);
      if (txd_i === 1'b1) got_q.push_back(b);
    end
  end
endmodule

// ==== sim/ucd_channel_tb.sv ====
// Self-checking testbench for the UART channel serial datapath
`timescale 1ns/1ps
module ucd_channel_tb import ucd_pkg::*;;
  logic clock_i = 1'b0, rst_i = 1'b1, tick = 1'b0, tx_run = 1'b1;
  logic [1:0] tcnt = 2'h0, mode = 2'h0;
  ucd_frame_cfg_t cfg = 5'h18;
  logic tx_en = 1'b0, tx_rst = 1'b0, rx_en = 1'b1, rx_rst = 1'b0, ovr_clr = 1'b0, brk_clr = 1'b0;
  logic wr = 1'b0, pop = 1'b0, one_x = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic txd, rxd, tx_ready, tx_empty, rx_valid, overrun, brk_chg;
  ucd_rx_entry_t entry;
  ucd_bid_t bid;
  int error_cnt = 0, checks = 0;

  // 8 ns clock; tick every fourth cycle as the 16x rate
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    tcnt <= tcnt + 2'h1;
    tick <= #1 (tcnt == 2'h3);
  end

  ucd_channel dut (.clock_i(clock_i), .rst_i(rst_i), .tx_tick_i(tick & tx_run), .rx_tick_i(tick),
    .frame_cfg_i(cfg), .tx_ext_clk_i(1'b0), .tx_1x_i(one_x), .rx_ext_clk_i(1'b0), .rx_1x_i(1'b0),
    .tx_bid_mode_i(mode), .channel_i(2'h2), .tx_enable_i(tx_en), .tx_reset_i(tx_rst),
    .rx_enable_i(rx_en), .rx_reset_i(rx_rst), .overrun_clr_i(ovr_clr), .brk_chg_clr_i(brk_clr),
    .wr_valid_i(wr), .wr_data_i(wdat), .rx_pop_i(pop), .rxd_i(rxd), .txd_o(txd),
    .tx_ready_o(tx_ready), .tx_empty_o(tx_empty), .rx_valid_o(rx_valid), .rx_entry_o(entry),
    .overrun_o(overrun), .brk_chg_o(brk_chg), .tx_bid_o(bid));

  ucd_far_uart u_far (.clock_i(clock_i), .tick_i(tick), .txd_i(txd), .cfg_i(cfg), .rxd_o(rxd));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Back-to-back host writes of consecutive bytes
  task automatic put(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      wr = 1'b1;
      wdat = d + 8'(i);
      cyc(1);
    end
    wr = 1'b0;
  endtask

  // Sends one frame, waits bounded for it, compares and pops
  task automatic rx_one(input logic [7:0] d, input logic pb, input logic sl, input logic [10:0] exp);
    int n;
    n = 0;
    u_far.send(d, pb, sl);
    while (rx_valid !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("rx entry", exp, entry);
    pop = 1'b1;
    cyc(1);
    pop = 1'b0;
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_tx_idle();
    put(8'h77, 1);
    chk("txd idle", 11'h1, 11'(txd));
    chk("ready while disabled", 11'h0, 11'(tx_ready));
    tx_en = 1'b1;
    cyc(2);
    chk("empty flag", 11'h1, 11'(tx_empty));
    chk("bid", {1'b0, 1'b1, 2'h2, TX_BID_KIND, 4'hf}, 11'(bid));
    $display("test tx_idle done");
  endtask

  task automatic t_tx();
    int n;
    n = 0;
    // A 1x request without an external clock must still run at 16x
    one_x = 1'b1;
    put(8'h3c, 2);
    while (txd !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("start latency", 11'h1, 11'(n <= 9));
    chk("empty while busy", 11'h0, 11'(tx_empty));
    n = 0;
    while (u_far.got_q.size() < 2 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk("tx byte 0", 11'h03c, {3'h0, u_far.got_q[0]});
    chk("tx byte 1", 11'h03d, {3'h0, u_far.got_q[1]});
    cyc(80);
    chk("empty after", 11'h1, 11'(tx_empty));
    u_far.got_q.delete();
    one_x = 1'b0;
    $display("test tx done");
  endtask

  // Transmitter held still so the fill level is steady
  task automatic t_bid();
    tx_run = 1'b0;
    put(8'h10, 4);
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      cyc(2);
      chk("bid valid by mode", 11'(m != 3), 11'(bid.valid));
    end
    // Eleven free: past the three-quarter mark, still half empty
    put(8'h14, 1);
    mode = BID_QUARTER;
    cyc(2);
    chk("bid quarter at 11 free", 11'h0, 11'(bid.valid));
    mode = BID_HALF;
    cyc(2);
    chk("bid half at 11 free", 11'h1, 11'(bid.valid));
    mode = BID_NOT_FULL;
    cyc(2);
    chk("bid level 11 free", 11'ha, 11'(bid.level));
    put(8'h20, 10);
    cyc(1);
    chk("bid level 1 free", 11'h0, 11'(bid.level));
    put(8'h30, 1);
    cyc(1);
    chk("ready when full", 11'h0, 11'(tx_ready));
    chk("no bid when full", 11'h0, 11'(bid.valid));
    tx_rst = 1'b1;
    cyc(1);
    tx_rst = 1'b0;
    tx_run = 1'b1;
    cyc(200);
    chk("bid after clear", 11'hf, 11'(bid.level));
    chk("nothing sent", 11'h0, 11'(u_far.got_q.size()));
    $display("test bid done");
  endtask

  task automatic t_rx();
    rx_one(8'ha5, 1'b0, 1'b0, 11'h0a5);
    cfg.len = 2'h0;
    rx_one(8'hff, 1'b0, 1'b0, 11'h01f);
    cfg = 5'h1e;
    rx_one(8'h5a, 1'b0, 1'b0, 11'h05a);
    rx_one(8'h5a, 1'b1, 1'b0, 11'h15a);
    cfg = 5'h18;
    rx_one(8'h55, 1'b0, 1'b1, 11'h255);
    rx_one(8'h00, 1'b0, 1'b1, 11'h400);
    chk("break change", 11'h1, 11'(brk_chg));
    brk_clr = 1'b1;
    cyc(1);
    brk_clr = 1'b0;
    cyc(1);
    chk("break change cleared", 11'h0, 11'(brk_chg));
    u_far.glitch(4);
    cyc(20);
    chk("glitch dropped", 11'h0, 11'(rx_valid));
    // Disabled receiver ignores a whole frame
    rx_en = 1'b0;
    u_far.send(8'h33, 1'b0, 1'b0);
    cyc(20);
    chk("disabled receiver", 11'h0, 11'(rx_valid));
    rx_en = 1'b1;
    $display("test rx done");
  endtask

  // Frames back to back with no pops fill buffer and hold
  task automatic t_ovr();
    for (int i = 0; i < 17; i++) u_far.send(8'(i + 1), 1'b0, 1'b0);
    chk("no overrun at 17", 11'h0, 11'(overrun));
    u_far.send(8'h40, 1'b0, 1'b0);
    chk("overrun", 11'h1, 11'(overrun));
    chk("head kept", 11'h001, entry);
    rx_rst = 1'b1;
    ovr_clr = 1'b1;
    cyc(1);
    rx_rst = 1'b0;
    ovr_clr = 1'b0;
    cyc(1);
    chk("overrun cleared", 11'h0, 11'(overrun));
    $display("test overrun done");
  endtask

  // Main sequence
  initial begin
    cyc(3);
    rst_i = 1'b0;
    t_tx_idle();
    t_tx();
    t_bid();
    t_rx();
    t_ovr();
    give_verdict();
  end

  // Watchdog, well beyond the expected run of about 18k cycles
  initial begin
    #400000;
    error_cnt++;
    $display("mismatch watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
